// *** hw/dual_pwm_timers.sv ***
// Dual PWM timer block: register file, two-phase timer and triple PWM unit
// Notes on behaviour
// - Timer A has 16-bit main and interval counters; all values reset to zero.
// - Timer A runs on slow 32 kHz clock, or divided fast clock when enabled.
// - Divide-by-ten prescaler, when enabled, slows only the interval counter.
// - Run bit starts timer A: counters load, interrupt raised at start.
// - Main counter at zero flips phase and reloads from the other shadow.
// - Primary output high in high phase; inverted output is its complement while running, and both are low when stopped.
// - Clocked mode outputs half the selected clock during the high phase.
// - Interval counter holds zero until low phase ends; then interrupt fires.
// - At cycle end counters and shadows reload from the value registers.
// - Phase value writes reach the shadows only at start and at cycle end.
// - Disabled timer A holds all state in reset; value registers keep contents.
// - Reads return live interval counter or live main counter at value addresses.
// - Freeze set stops timer A counting; freeze clear resumes it.
// - Timer B runs on divided system clock only while enabled.
// - Period counter counts down, sets outputs at zero and reloads.
// - Duty up-counter starts at zero, clears matching outputs, zero period holds it.
// - Radio activity with pause enabled freezes duty counter and forces outputs low.
// - Clearing pause enable ignores radio activity, duty cycle unchanged.
// - Radio activity comes from hardware inputs, never from software bits.
`timescale 1ns/1ps
`default_nettype none
module dual_pwm_timers
  import pwm_timer_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic          clk_en,
  input  wire reg_req_type   req,
  input  wire logic          slow_clk_pin,
  input  wire radio_act_type radio,
  output logic [15:0]        rd_data,
  output logic               timer_a_primary_out,
  output logic               timer_a_inverted_out,
  output logic               timer_a_interval_irq,
  output logic [2:0]         timer_b_output
);

  typedef struct packed {
    // Software registers
    logic             run;
    logic             fast_clock_select;
    logic             interval_div10_enable;
    logic             clock_out_mode;
    logic [15:0]      high_phase_value;
    logic [15:0]      low_phase_value;
    logic [15:0]      interval_value;
    logic             freeze;
    logic             timer_clock_enable;
    logic [1:0]       timer_clock_divider;
    logic             timer_b_enable;
    logic             radio_pause_enable;
    logic [13:0]      timer_b_period;
    logic [2:0][13:0] output_duty_value;
    // Timer A state
    logic [15:0]      main_down_counter;
    logic [15:0]      interval_counter;
    logic [15:0]      high_shadow;
    logic [15:0]      low_shadow;
    logic             low_phase;
    logic             active;
    logic [3:0]       prescale_cnt;
    logic             half_clk;
    logic             primary;
    logic             inverted;
    logic             irq;
    // Read data, valid one cycle after the strobe
    logic [15:0]      rdata;
  } unit_state_type;

  unit_state_type  s_reg, s_next;
  logic            div_tick;
  logic            slow_tick;
  logic            tick_a;
  logic [2:0]      b_out;
  timer_b_cfg_type b_cfg;
  logic            cycle_end;

  function automatic logic hits(input reg_req_type r, input logic [7:0] ofs);
    hits = r.addr == ofs;
  endfunction : hits

  timer_tick_gen u_tick_gen (
    .core_clk      (core_clk),
    .reset         (reset),
    .clk_en        (clk_en),
    .slow_clk_pin  (slow_clk_pin),
    .clock_divider (s_reg.timer_clock_divider),
    .div_tick      (div_tick),
    .slow_tick     (slow_tick)
  );

  assign b_cfg.enable = s_reg.timer_b_enable;
  assign b_cfg.pause_en = s_reg.radio_pause_enable;
  assign b_cfg.period = s_reg.timer_b_period;
  assign b_cfg.duty = s_reg.output_duty_value;

  // Duty values at or above the period simply never clear their output
  timer_b_unit u_timer_b (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .tick     (div_tick),
    .cfg      (b_cfg),
    .radio    (radio),
    .pwm_out  (b_out)
  );

  // Fast sources need both select and clock enable; slow source needs none
  assign tick_a = s_reg.fast_clock_select ? (s_reg.timer_clock_enable & div_tick) : slow_tick;

  assign cycle_end = s_reg.low_phase && s_reg.main_down_counter == VALUE_RST
                     && s_reg.interval_counter == VALUE_RST;

  always_comb begin
    logic interval_tick;
    interval_tick = 1'b0;
    s_next = s_reg;

    // Register writes
    if (req.wr) begin
      if (hits(req, OFS_CTRL_A)) begin
        s_next.run = req.wdata[RUN_BIT];
        s_next.fast_clock_select = req.wdata[FAST_SEL_BIT];
        s_next.interval_div10_enable = req.wdata[DIV10_BIT];
        s_next.clock_out_mode = req.wdata[CLK_MODE_BIT];
      end
      if (hits(req, OFS_HIGH)) begin
        s_next.high_phase_value = req.wdata;
      end
      if (hits(req, OFS_LOW)) begin
        s_next.low_phase_value = req.wdata;
      end
      if (hits(req, OFS_INTERVAL)) begin
        s_next.interval_value = req.wdata;
      end
      if (hits(req, OFS_FREEZE_SET) && req.wdata[FREEZE_BIT]) begin
        s_next.freeze = 1'b1;
      end
      if (hits(req, OFS_FREEZE_CLR) && req.wdata[FREEZE_BIT]) begin
        s_next.freeze = 1'b0;
      end
      if (hits(req, OFS_CLK_CTRL)) begin
        s_next.timer_clock_enable = req.wdata[CLK_EN_BIT];
        s_next.timer_clock_divider = req.wdata[CLK_DIV_LSB +: 2];
      end
      if (hits(req, OFS_CTRL_B)) begin
        s_next.timer_b_enable = req.wdata[B_EN_BIT];
        s_next.radio_pause_enable = req.wdata[B_PAUSE_BIT];
      end
      if (hits(req, OFS_PERIOD)) begin
        s_next.timer_b_period = req.wdata[13:0];
      end
      if (hits(req, OFS_DUTY0)) begin
        s_next.output_duty_value[0] = req.wdata[13:0];
      end
      if (hits(req, OFS_DUTY1)) begin
        s_next.output_duty_value[1] = req.wdata[13:0];
      end
      if (hits(req, OFS_DUTY2)) begin
        s_next.output_duty_value[2] = req.wdata[13:0];
      end
    end

    // Register reads: value addresses show live counters
    s_next.rdata = VALUE_RST;
    if (req.rd) begin
      unique case (req.addr)
        OFS_CTRL_A:   s_next.rdata = {12'h000, s_reg.clock_out_mode, s_reg.interval_div10_enable,
                                      s_reg.fast_clock_select, s_reg.run};
        OFS_HIGH:     s_next.rdata = s_reg.main_down_counter;
        OFS_LOW:      s_next.rdata = s_reg.main_down_counter;
        OFS_INTERVAL: s_next.rdata = s_reg.interval_counter;
        OFS_CLK_CTRL: s_next.rdata = {13'h0000, s_reg.timer_clock_divider, s_reg.timer_clock_enable};
        OFS_CTRL_B:   s_next.rdata = {14'h0000, s_reg.radio_pause_enable, s_reg.timer_b_enable};
        OFS_PERIOD:   s_next.rdata = {2'b00, s_reg.timer_b_period};
        OFS_DUTY0:    s_next.rdata = {2'b00, s_reg.output_duty_value[0]};
        OFS_DUTY1:    s_next.rdata = {2'b00, s_reg.output_duty_value[1]};
        OFS_DUTY2:    s_next.rdata = {2'b00, s_reg.output_duty_value[2]};
        OFS_STATUS:   s_next.rdata = {10'h000, b_out, s_reg.freeze, s_reg.low_phase, s_reg.active};
        default:      s_next.rdata = VALUE_RST;
      endcase
    end

    // Timer A
    s_next.irq = 1'b0;
    if (!s_reg.run) begin
      // Value registers survive; everything else is cleared
      s_next.main_down_counter = VALUE_RST;
      s_next.interval_counter = VALUE_RST;
      s_next.high_shadow = VALUE_RST;
      s_next.low_shadow = VALUE_RST;
      s_next.low_phase = 1'b0;
      s_next.active = 1'b0;
      s_next.prescale_cnt = 4'h0;
      s_next.half_clk = 1'b0;
    end else if (s_reg.freeze) begin
      s_next.active = s_reg.active;
    end else if (!s_reg.active) begin
      // Counters load from the value registers and the phase starts high; start-up interrupts
      s_next.active = 1'b1;
      s_next.irq = 1'b1;
      s_next.main_down_counter = s_reg.high_phase_value;
      s_next.high_shadow = s_reg.high_phase_value;
      s_next.low_shadow = s_reg.low_phase_value;
      s_next.interval_counter = s_reg.interval_value;
      s_next.low_phase = 1'b0;
    end else if (tick_a) begin
      s_next.half_clk = ~s_reg.half_clk;
      if (s_reg.interval_div10_enable) begin
        if (s_reg.prescale_cnt == INTERVAL_PRESCALE - 4'h1) begin
          s_next.prescale_cnt = 4'h0;
          interval_tick = 1'b1;
        end else begin
          s_next.prescale_cnt = s_reg.prescale_cnt + 4'h1;
        end
      end else begin
        interval_tick = 1'b1;
      end
      if (interval_tick && s_reg.interval_counter != VALUE_RST) begin
        s_next.interval_counter = s_reg.interval_counter - 16'h0001;
      end
      if (cycle_end) begin
        // Missed events possible with fast clock and small values
        s_next.irq = 1'b1;
        s_next.interval_counter = s_reg.interval_value;
        s_next.main_down_counter = s_reg.high_phase_value;
        s_next.high_shadow = s_reg.high_phase_value;
        s_next.low_shadow = s_reg.low_phase_value;
        s_next.low_phase = 1'b0;
      end else if (s_reg.main_down_counter == VALUE_RST) begin
        s_next.low_phase = ~s_reg.low_phase;
        s_next.main_down_counter = s_reg.low_phase ? s_reg.high_shadow : s_reg.low_shadow;
      end else begin
        s_next.main_down_counter = s_reg.main_down_counter - 16'h0001;
      end
    end

    // Outputs registered from the next state
    s_next.primary = s_next.active && !s_next.low_phase
                     && (!s_reg.clock_out_mode || s_next.half_clk);
    s_next.inverted = s_next.active && !s_next.primary;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rdata;
  assign timer_a_primary_out = s_reg.primary;
  assign timer_a_inverted_out = s_reg.inverted;
  assign timer_a_interval_irq = s_reg.irq;
  assign timer_b_output = b_out;

  a_outputs_complement: assert property (@(posedge core_clk) disable iff (reset)
    s_reg.active |-> (s_reg.primary != s_reg.inverted))
    else $error("inverted output is not the complement while running");

  a_start_loads: assert property (@(posedge core_clk) disable iff (reset)
    $rose(s_reg.active) |-> (s_reg.irq && !s_reg.low_phase
                             && s_reg.main_down_counter == $past(s_reg.high_phase_value)))
    else $error("start did not load high value and raise interrupt");

  a_disabled_cleared: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && !s_reg.run) |=> (s_reg.main_down_counter == VALUE_RST
                               && s_reg.interval_counter == VALUE_RST
                               && !s_reg.primary && !s_reg.inverted && !s_reg.active))
    else $error("disabled timer state not cleared");

  a_freeze_holds: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && s_reg.freeze && s_reg.run && s_reg.active)
      |=> ($stable(s_reg.main_down_counter) && $stable(s_reg.interval_counter) && !s_reg.irq))
    else $error("frozen timer counters moved");

  // Clock enable low keeps the pulse up, so only a freshly registered pulse is judged
  a_irq_cause: assert property (@(posedge core_clk) disable iff (reset)
    (s_reg.irq && $past(s_reg.active) && $past(clk_en))
      |-> $past(cycle_end))
    else $error("interrupt without interval and low phase both at zero");

  a_cycle_reload: assert property (@(posedge core_clk) disable iff (reset)
    (s_reg.irq && $past(s_reg.active) && $past(clk_en))
      |-> (s_reg.interval_counter == $past(s_reg.interval_value)
           && s_reg.low_shadow == $past(s_reg.low_phase_value)
           && s_reg.main_down_counter == $past(s_reg.high_phase_value)))
    else $error("cycle end did not reload from value registers");

  a_shadow_stable: assert property (@(posedge core_clk) disable iff (reset)
    (s_reg.active && $past(s_reg.active) && !s_reg.irq) |-> ($stable(s_reg.high_shadow)
                                                             && $stable(s_reg.low_shadow)))
    else $error("shadow changed outside cycle end");

  a_interval_read: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && req.rd && hits(req, OFS_INTERVAL)) |=> (rd_data == $past(s_reg.interval_counter)))
    else $error("interval address did not return live interval counter");

  a_phase_read: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && req.rd && (hits(req, OFS_HIGH) || hits(req, OFS_LOW)))
      |=> (rd_data == $past(s_reg.main_down_counter)))
    else $error("phase address did not return live main counter");

  a_slow_source: assert property (@(posedge core_clk) disable iff (reset)
    (!s_reg.fast_clock_select && !slow_tick && s_reg.active && !s_reg.freeze && s_reg.run && clk_en)
      |=> $stable(s_reg.main_down_counter))
    else $error("main counter moved without slow clock tick");

  a_fast_gated: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && s_reg.fast_clock_select && !s_reg.timer_clock_enable && s_reg.active && s_reg.run && !s_reg.freeze)
      |=> $stable(s_reg.main_down_counter))
    else $error("fast source counted without the clock enable");

  a_counter_step: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && tick_a && s_reg.run && !s_reg.freeze && s_reg.active && s_reg.main_down_counter != VALUE_RST)
      |=> (s_reg.main_down_counter == $past(s_reg.main_down_counter) - 16'h0001))
    else $error("main counter did not step down on a selected tick");

  a_phase_flip: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && tick_a && s_reg.run && !s_reg.freeze && s_reg.active && !cycle_end
     && s_reg.main_down_counter == VALUE_RST)
      |=> (s_reg.low_phase != $past(s_reg.low_phase)
           && s_reg.main_down_counter == ($past(s_reg.low_phase) ? $past(s_reg.high_shadow)
                                                                 : $past(s_reg.low_shadow))))
    else $error("phase did not flip and reload from the other shadow");

  a_prescale_hold: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && tick_a && s_reg.run && !s_reg.freeze && s_reg.active && s_reg.interval_div10_enable
     && s_reg.prescale_cnt != INTERVAL_PRESCALE - 4'h1 && !cycle_end)
      |=> $stable(s_reg.interval_counter))
    else $error("interval counter moved between prescaler wraps");

  a_clocked_output: assert property (@(posedge core_clk) disable iff (reset)
    (s_reg.active && !s_reg.low_phase && $past(s_reg.clock_out_mode)) |-> (s_reg.primary == s_reg.half_clk))
    else $error("clocked mode output does not follow the half-rate clock");

  a_plain_level: assert property (@(posedge core_clk) disable iff (reset)
    (s_reg.active && !$past(s_reg.clock_out_mode)) |-> (s_reg.primary == !s_reg.low_phase))
    else $error("primary output does not follow the phase");

endmodule : dual_pwm_timers
`default_nettype wire

// *** hw/pwm_timer_pkg.sv ***
// Shared constants and carrier types for the dual PWM timer block
package pwm_timer_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_A     = 8'h00;
  localparam logic [7:0] OFS_HIGH       = 8'h04;
  localparam logic [7:0] OFS_LOW        = 8'h08;
  localparam logic [7:0] OFS_INTERVAL   = 8'h0C;
  localparam logic [7:0] OFS_FREEZE_SET = 8'h10;
  localparam logic [7:0] OFS_FREEZE_CLR = 8'h14;
  localparam logic [7:0] OFS_CLK_CTRL   = 8'h18;
  localparam logic [7:0] OFS_CTRL_B     = 8'h1C;
  localparam logic [7:0] OFS_PERIOD     = 8'h20;
  localparam logic [7:0] OFS_DUTY0      = 8'h24;
  localparam logic [7:0] OFS_DUTY1      = 8'h28;
  localparam logic [7:0] OFS_DUTY2      = 8'h2C;
  localparam logic [7:0] OFS_STATUS     = 8'h30;

  // Field positions
  localparam int RUN_BIT      = 0;
  localparam int FAST_SEL_BIT = 1;
  localparam int DIV10_BIT    = 2;
  localparam int CLK_MODE_BIT = 3;
  localparam int FREEZE_BIT   = 0;
  localparam int CLK_EN_BIT   = 0;
  localparam int CLK_DIV_LSB  = 1;
  localparam int B_EN_BIT     = 0;
  localparam int B_PAUSE_BIT  = 1;

  // Reset value of every register and counter
  localparam logic [15:0] VALUE_RST = 16'h0000;

  // Timing: 200 MHz core clock, 16 MHz fastest timer clock
  localparam int SYS_CLK_KHZ  = 200000;
  localparam int BASE_CLK_KHZ = 16000;
  localparam logic [8:0] ACC_STEP = 9'(BASE_CLK_KHZ / 1000);
  localparam logic [8:0] ACC_MOD  = 9'(SYS_CLK_KHZ / 1000);
  localparam logic [3:0] INTERVAL_PRESCALE = 4'hA;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;

  typedef struct packed {
    logic             enable;
    logic             pause_en;
    logic [13:0]      period;
    logic [2:0][13:0] duty;
  } timer_b_cfg_type;

  typedef struct packed {
    logic tx_active;
    logic rx_active;
  } radio_act_type;

endpackage : pwm_timer_pkg

// *** hw/timer_tick_gen.sv ***
// Timer clock enables: divided fast ticks and synchronised slow clock ticks
`timescale 1ns/1ps
`default_nettype none
module timer_tick_gen
  import pwm_timer_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic       slow_clk_pin,
  input  wire logic [1:0] clock_divider,
  output logic            div_tick,
  output logic            slow_tick
);

  typedef struct packed {
    logic [7:0] acc;
    logic [2:0] div_cnt;
    logic       slow_meta;
    logic       slow_sync;
    logic       slow_prev;
    logic       div_tick;
    logic       slow_tick;
  } tick_state_type;

  tick_state_type s_reg, s_next;

  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    div_mask = 3'((4'h1 << sel) - 4'h1);
  endfunction : div_mask

  always_comb begin
    logic [8:0] sum;
    logic       base;
    sum = 9'h000;
    base = 1'b0;
    s_next = s_reg;
    // Fractional accumulator: 200 MHz does not divide evenly to 16 MHz
    sum = {1'b0, s_reg.acc} + ACC_STEP;
    if (sum >= ACC_MOD) begin
      sum = sum - ACC_MOD;
      base = 1'b1;
    end
    s_next.acc = sum[7:0];
    s_next.div_tick = 1'b0;
    if (base) begin
      s_next.div_cnt = s_reg.div_cnt + 3'h1;
      s_next.div_tick = (s_reg.div_cnt & div_mask(clock_divider)) == 3'h0;
    end
    s_next.slow_meta = slow_clk_pin;
    s_next.slow_sync = s_reg.slow_meta;
    s_next.slow_prev = s_reg.slow_sync;
    s_next.slow_tick = s_reg.slow_sync & ~s_reg.slow_prev;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign div_tick = s_reg.div_tick;
  assign slow_tick = s_reg.slow_tick;

endmodule : timer_tick_gen
`default_nettype wire

// *** hw/timer_b_unit.sv ***
// Three-output PWM unit with shared period and duty counters
`timescale 1ns/1ps
`default_nettype none
module timer_b_unit
  import pwm_timer_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            reset,
  input  wire logic            clk_en,
  input  wire logic            tick,
  input  wire timer_b_cfg_type cfg,
  input  wire radio_act_type   radio,
  output logic [2:0]           pwm_out
);

  typedef struct packed {
    logic [13:0] period_cnt;
    logic [13:0] duty_cnt;
    logic [2:0]  level;
    logic [2:0]  out;
    logic [1:0]  radio_meta;
    logic [1:0]  radio_sync;
  } b_state_type;

  b_state_type s_reg, s_next;
  logic        paused;

  // Radio hardware indications only; no software path reaches them
  assign paused = cfg.pause_en & (|s_reg.radio_sync);

  always_comb begin
    s_next = s_reg;
    s_next.radio_meta = {radio.tx_active, radio.rx_active};
    s_next.radio_sync = s_reg.radio_meta;
    if (!cfg.enable) begin
      s_next.period_cnt = 14'h0000;
      s_next.duty_cnt = 14'h0000;
      s_next.level = 3'b000;
    end else if (cfg.period == 14'h0000) begin
      // Held every cycle, not only on ticks, so a cleared period stops it at once
      s_next.duty_cnt = 14'h0000;
    end else if (tick) begin
      if (s_reg.period_cnt == 14'h0000) begin
        s_next.period_cnt = cfg.period;
        s_next.level = 3'b111;
        s_next.duty_cnt = 14'h0000;
      end else begin
        s_next.period_cnt = s_reg.period_cnt - 14'h0001;
        if (!paused) begin
          s_next.duty_cnt = s_reg.duty_cnt + 14'h0001;
          // One shared duty counter against three duty values
          for (int i = 0; i < 3; i++) begin
            if (s_reg.duty_cnt == cfg.duty[i]) begin
              s_next.level[i] = 1'b0;
            end
          end
        end
      end
    end
    s_next.out = (cfg.enable && !paused) ? s_next.level : 3'b000;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign pwm_out = s_reg.out;

  a_pause_forces_low: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && paused) |=> (pwm_out == 3'b000))
    else $error("outputs not low during radio pause");

  a_pause_holds_duty: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && paused && cfg.enable && cfg.period != 14'h0000 && s_reg.period_cnt != 14'h0000)
      |=> $stable(s_reg.duty_cnt))
    else $error("duty counter moved during radio pause");

  a_zero_period_duty: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && cfg.period == 14'h0000) |=> (s_reg.duty_cnt == 14'h0000))
    else $error("duty counter not held at zero with zero period");

endmodule : timer_b_unit
`default_nettype wire

// *** verification/pin_partner.sv ***
// Far-side model: slow clock pin and radio activity lines
`timescale 1ns/1ps
`default_nettype none
module pin_partner
  import pwm_timer_pkg::*;
#(parameter int HALF = 20)
(
  input  wire logic     core_clk,
  input  wire logic     tx_cmd,
  input  wire logic     rx_cmd,
  output logic          slow_clk_pin,
  output radio_act_type radio
);
  int cnt_reg = 0;
  // Slow clock far faster than 32 kHz so that runs stay short
  initial slow_clk_pin = 1'b0;
  initial radio = '0;
  always @(posedge core_clk) begin
    cnt_reg <= (cnt_reg == HALF - 1) ? 0 : cnt_reg + 1;
    if (cnt_reg == HALF - 1) slow_clk_pin <= ~slow_clk_pin;
  end
  // Activity levels come from the radio side only
  always @(posedge core_clk) radio <= '{tx_active: tx_cmd, rx_active: rx_cmd};
endmodule : pin_partner
`default_nettype wire

// *** verification/dual_pwm_timers_tb.sv ***
// Self-checking bench for the dual PWM timer block
`timescale 1ns/1ps
`default_nettype none
module dual_pwm_timers_tb;
  import pwm_timer_pkg::*;
  localparam int P  = 40;
  localparam int BT = 100;
  logic          core_clk = 1'b0;
  logic          reset    = 1'b1;
  logic          clk_en   = 1'b1;
  reg_req_type   req      = '0;
  logic          tx_cmd   = 1'b0;
  logic          rx_cmd   = 1'b0;
  logic          slow_clk_pin;
  radio_act_type radio;
  logic [15:0]   rd_data, v0, v1;
  logic          pri, inv, irq;
  logic [2:0]    bout;
  int            miscompares = 0;
  int            comparisons = 0;
  int            cycles      = 0;
  int            n, hi, lo;
  int            duty[3];
  logic [7:0]    ra[5] = '{OFS_HIGH, OFS_LOW, OFS_INTERVAL, OFS_FREEZE_CLR, 8'h3C};

  dual_pwm_timers u_dual_pwm_timers (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .req(req),
    .slow_clk_pin(slow_clk_pin), .radio(radio), .rd_data(rd_data), .timer_a_primary_out(pri),
    .timer_a_inverted_out(inv), .timer_a_interval_irq(irq), .timer_b_output(bout));
  pin_partner #(.HALF(P / 2)) u_pin_partner (.core_clk(core_clk), .tx_cmd(tx_cmd), .rx_cmd(rx_cmd),
    .slow_clk_pin(slow_clk_pin), .radio(radio));

  initial forever #2.5 core_clk = ~core_clk;

  task automatic finish_test;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // Hang guard well above the expected few thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  // Ticks between interrupts: whole PWM periods until the interval count is spent
  function automatic int a_gap(input int m, input int nl, input int on);
    int k;
    k = 1;
    while (k * (m + nl + 2) < on) k++;
    return k * (m + nl + 2);
  endfunction : a_gap

  task automatic irq_gap(output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      #1;
      c++;
    end while (irq !== 1'b1 && c < 5000);
  endtask : irq_gap

  task automatic span(input logic lvl, output int c);
    c = 0;
    #1;
    while (pri === lvl && c < 5000) begin
      @(posedge core_clk);
      #1;
      c++;
    end
    check(inv, !pri);
  endtask : span

  task automatic wait_b0(input logic lvl);
    int c = 0;
    while (bout[0] !== lvl && c < 2000) begin
      @(posedge core_clk);
      #1;
      c++;
    end
  endtask : wait_b0

  task automatic bmeas;
    int c[3] = '{0, 0, 0};
    wait_b0(1'b0);
    wait_b0(1'b1);
    repeat (6 * BT) begin
      foreach (c[k]) c[k] += int'(bout[k] === 1'b1);
      @(posedge core_clk);
      #1;
    end
    foreach (c[k]) check(c[k], (duty[k] + 1) * BT);
  endtask : bmeas

  initial begin
    void'($urandom(39594));
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i], v0);
      check(v0, VALUE_RST);
    end
    wr(OFS_HIGH, 16'h0002);
    wr(OFS_LOW, 16'h0001);
    wr(OFS_INTERVAL, 16'h0006);
    rd(OFS_HIGH, v0);
    check(v0, VALUE_RST);
    wr(OFS_CTRL_A, 16'h0001);
    irq_gap(n);
    check(n <= 4 && pri === 1'b1, 1);
    irq_gap(n);
    irq_gap(n);
    check(n, a_gap(2, 1, 6) * P);
    // Mid-cycle write must wait for the cycle end
    wr(OFS_HIGH, 16'h0005);
    span(1'b1, n);
    span(1'b0, lo);
    span(1'b1, hi);
    check(lo, 2 * P);
    check(hi, 3 * P);
    span(1'b0, n);
    span(1'b1, hi);
    check(hi, 6 * P);
    wr(OFS_FREEZE_SET, 16'h0001);
    rd(OFS_HIGH, v0);
    repeat (3 * P) @(posedge core_clk);
    rd(OFS_LOW, v1);
    check(v1, v0);
    wr(OFS_FREEZE_CLR, 16'h0001);
    repeat (3 * P) @(posedge core_clk);
    rd(OFS_HIGH, v1);
    check(v1 != v0, 1);
    wr(OFS_CTRL_A, 16'h0000);
    rd(OFS_INTERVAL, v0);
    check({pri, inv, irq, v0}, 0);
    wr(OFS_CTRL_A, 16'h0001);
    irq_gap(n);
    irq_gap(n);
    irq_gap(n);
    check(n, a_gap(5, 1, 6) * P);
    // Two-tick PWM period; divided interval stretches the cycle to twelve ticks
    wr(OFS_CTRL_A, 16'h0000);
    wr(OFS_HIGH, 16'h0000);
    wr(OFS_LOW, 16'h0000);
    wr(OFS_INTERVAL, 16'h0001);
    wr(OFS_CTRL_A, 16'h0005);
    irq_gap(n);
    irq_gap(n);
    check(n > 11 * P && n <= 12 * P, 1);
    wr(OFS_CTRL_A, 16'h0000);
    wr(OFS_HIGH, 16'h0003);
    wr(OFS_CTRL_A, 16'h0009);
    irq_gap(n);
    span(1'b0, n);
    span(1'b1, hi);
    check(hi, P);
    wr(OFS_CLK_CTRL, 16'h0006);
    foreach (duty[k]) begin
      duty[k] = $urandom_range(4, 0);
      wr(OFS_DUTY0 + 8'(4 * k), 16'(duty[k]));
    end
    wr(OFS_PERIOD, 16'h0005);
    wr(OFS_CTRL_B, 16'h0001);
    bmeas();
    @(posedge core_clk);
    if ($urandom_range(1, 0) == 1) tx_cmd <= 1'b1;
    else rx_cmd <= 1'b1;
    bmeas();
    wr(OFS_CTRL_B, 16'h0003);
    repeat (6) @(posedge core_clk);
    #1 check(bout, 0);
    @(posedge core_clk);
    tx_cmd <= 1'b0;
    rx_cmd <= 1'b0;
    repeat (7 * BT) @(posedge core_clk);
    bmeas();
    finish_test();
  end
endmodule : dual_pwm_timers_tb
`default_nettype wire
